//--- gpc_cfg.svh
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// register byte addresses
`define GPC_OFF_C1_RAW     8'h00
`define GPC_OFF_C1_GEARED  8'h04
`define GPC_OFF_C1_TARGET  8'h08
`define GPC_OFF_C1_LIMIT   8'h0C
`define GPC_OFF_GEAR_DIV   8'h10
`define GPC_OFF_GEAR_MUL   8'h14
`define GPC_OFF_C2_VALUE   8'h18
`define GPC_OFF_C2_TARGET  8'h1C
`define GPC_OFF_C2_LIMIT   8'h20
`define GPC_OFF_WRAP_SEL   8'h24
`define GPC_OFF_STATUS     8'h28
`define GPC_OFF_MASK       8'h2C
`define GPC_OFF_DI_BASE    8'h30
`define GPC_OFF_DO_BASE    8'h40

// reset values
`define GPC_RST_C1_TARGET  32'h000003E8
`define GPC_RST_C1_LIMIT   32'hFFFFFFFF
`define GPC_RST_GEAR       16'h0001
`define GPC_RST_C2_TARGET  16'h03E8
`define GPC_RST_C2_LIMIT   16'hFFFF
`define GPC_RST_WRAP       16'h000B

// legal overflow action values, decimal digits per counter
`define GPC_WRAP_NONE      16'h0000
`define GPC_WRAP_UNITS     16'h0001
`define GPC_WRAP_TENS      16'h000A
`define GPC_WRAP_BOTH      16'h000B

// terminal function codes
`define GPC_FN_C1_IN       8'h32
`define GPC_FN_C1_CLR      8'h33
`define GPC_FN_C2_IN       8'h34
`define GPC_FN_C2_CLR      8'h35
`define GPC_FN_C1_ARRIVE   8'h15
`define GPC_FN_C2_ARRIVE   8'h16

// status bit positions
`define GPC_ST_C1_ARRIVE   0
`define GPC_ST_C1_OVF      1
`define GPC_ST_C2_ARRIVE   2
`define GPC_ST_C2_OVF      3
`define GPC_ST_W           4

// gear multiplier and divisor width
`define GPC_GEAR_W         16

`endif

//--- gpc_pkg.sv
package gpc_pkg;
  typedef logic [31:0] gpc_word_t;
  typedef logic [15:0] gpc_half_t;
  typedef logic [7:0]  gpc_addr_t;
  typedef logic [7:0]  gpc_code_t;
  typedef enum {GPC_DIV_IDLE, GPC_DIV_RUN} gpc_div_e;
endpackage

//--- gpc_term_sel.sv
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module gpc_term_sel #(
  parameter int              NUM_DI = 4,
  parameter gpc_pkg::gpc_code_t CODE = 8'h00
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // terminals and their function codes
  input  wire logic [NUM_DI-1:0]   din,
  input  wire logic [NUM_DI*8-1:0] codes,
  // selected signal
  output logic                   level,
  output logic                   rise
);
  import gpc_pkg::*;

  logic [NUM_DI-1:0] match;
  logic              next_level;

  // a terminal counts when its function code names this function
  for (genvar i = 0; i < NUM_DI; i++) begin : g_match
    assign match[i] = din[i] && (codes[i*8 +: 8] == CODE);
  end
  assign next_level = |match;

  // registered level and its rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      level <= next_level;
      rise  <= next_level && !level;
    end
  end
endmodule

//--- gpc_gear_div.sv
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module gpc_gear_div #(
  parameter int CW = 32
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // request
  input  wire logic              start,
  input  wire logic [CW-1:0]     dividend,
  input  wire gpc_pkg::gpc_half_t mul,
  input  wire gpc_pkg::gpc_half_t den,
  // answer
  output logic                   busy,
  output logic                   done,
  output logic [CW-1:0]          quot
);
  import gpc_pkg::*;

  localparam int PW        = CW + `GPC_GEAR_W;
  // start edge to done: one cycle per product bit, plus the result register
  localparam int DIV_STEPS = PW + 1;

  if (CW < 16 || CW > 32) begin : g_bad_width
    $error("gear divider width out of range");
  end

  gpc_div_e          state;
  logic [PW-1:0]     dvd;
  logic [PW-1:0]     q;
  logic [16:0]       rem;
  logic [15:0]       den_q;
  logic [5:0]        step;
  logic [16:0]       trial;
  logic              fits;
  logic [PW-1:0]     q_full;
  logic              last;

  // one restoring step per cycle over the whole product
  assign trial  = {rem[15:0], dvd[PW-1]};
  assign fits   = trial >= {1'b0, den_q};
  assign q_full = {q[PW-2:0], fits};
  assign last   = (state == GPC_DIV_RUN) && (step == 6'(PW - 1));
  assign busy   = (state == GPC_DIV_RUN);

  // product of count and multiplier divided by divisor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= GPC_DIV_IDLE;
      dvd   <= '0;
      q     <= '0;
      rem   <= '0;
      den_q <= 16'h0001;
      step  <= '0;
    end else begin
      unique case (state)
        GPC_DIV_IDLE: begin
          if (start) begin
            state <= GPC_DIV_RUN;
            dvd   <= PW'(dividend) * PW'(mul); // see (RULE10)
            den_q <= den;
            rem   <= '0;
            q     <= '0;
            step  <= '0;
          end
        end
        GPC_DIV_RUN: begin
          dvd  <= {dvd[PW-2:0], 1'b0};
          rem  <= fits ? (trial - {1'b0, den_q}) : trial;
          q    <= q_full;
          step <= step + 6'h01;
          if (last) begin
            state <= GPC_DIV_IDLE;
          end
        end
      endcase
    end
  end

  // result, saturated when it does not fit the counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
      quot <= '0;
    end else begin
      done <= last;
      if (last) begin
        quot <= (|q_full[PW-1:CW]) ? '1 : q_full[CW-1:0]; // see (RULE10)
      end
    end
  end

  sequence s_div_launch;
    start && !busy;
  endsequence

  div_latency_a: assert property (@(posedge clk) disable iff (rst) // see (RULE10)
    s_div_launch |-> ##DIV_STEPS done)
    else $error("gear result not ready after fixed step count");
endmodule

//--- gpc_top.sv
// What this block does
// (RULE1) counter one is 32 bits; its pulses are geared before target comparison
// (RULE2) counter two is 16 bits, ungeared, target 1..65535, maximum defaults 65535
// (RULE3) counter one counts pulses from any terminal set to input function 50
// (RULE4) geared count at target drives output function 21; counting continues
// (RULE5) counter one at its maximum applies its selected overflow action
// (RULE6) action units digit counter one, tens counter two; 0 stop, 1 continue
// (RULE7) terminal set to reset function 51 clears counter one while active
// (RULE8) counter two value is read only and kept across power loss
// (RULE9) counter one raw and geared values are read only and kept across power loss
// (RULE10) geared count is raw times multiplier over divisor, each 1..65535
// (RULE11) counter two has its own input, reset and arrival functions like counter one
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module gpc_top #(
  parameter int NUM_DI = 4,
  parameter int NUM_DO = 2
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // register port
  input  wire gpc_pkg::gpc_addr_t reg_addr,
  input  wire gpc_pkg::gpc_word_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output gpc_pkg::gpc_word_t      reg_rdata,
  // terminals
  input  wire logic [NUM_DI-1:0]  din,
  output logic [NUM_DO-1:0]       dout,
  // retained values
  input  wire logic               power_fail,
  input  wire logic               nv_restore,
  input  wire gpc_pkg::gpc_word_t nv_load_raw,
  input  wire gpc_pkg::gpc_half_t nv_load_c2,
  output logic                    nv_save,
  output gpc_pkg::gpc_word_t      c1_count_raw,
  output gpc_pkg::gpc_word_t      c1_count_geared,
  output gpc_pkg::gpc_half_t      counter_two_value,
  // interrupt
  output logic                    irq
);
  import gpc_pkg::*;

  if (NUM_DI < 1 || NUM_DI > 4 || NUM_DO < 1 || NUM_DO > 4) begin : g_bad_count
    $error("terminal count out of range");
  end

  // units digit for counter one, tens digit for counter two
  function automatic logic wrap_continues(input gpc_half_t sel, input logic tens);
    if (tens) begin
      wrap_continues = (sel == `GPC_WRAP_TENS) || (sel == `GPC_WRAP_BOTH);
    end else begin
      wrap_continues = (sel == `GPC_WRAP_UNITS) || (sel == `GPC_WRAP_BOTH);
    end
  endfunction

  function automatic logic wr_at(input gpc_addr_t a, input gpc_addr_t off, input logic wr);
    wr_at = wr && (a == off);
  endfunction

  gpc_word_t            counter_one_target;
  gpc_word_t            counter_one_limit;
  gpc_half_t            gear_divisor;
  gpc_half_t            gear_multiplier;
  gpc_half_t            counter_two_target;
  gpc_half_t            counter_two_limit;
  gpc_half_t            wrap_behaviour_select;
  logic [`GPC_ST_W-1:0] status;
  logic [`GPC_ST_W-1:0] mask;
  gpc_code_t            di_func [NUM_DI];
  gpc_code_t            do_func [NUM_DO];
  logic [NUM_DI*8-1:0]  di_codes;
  logic                 c1_pulse, c1_clr, c2_pulse, c2_clr;
  logic                 c1_at_limit, c2_at_limit, c1_cont, c2_cont;
  logic                 c1_wrap, c1_ovf_ev, c2_wrap, c2_ovf_ev, c1_zero;
  logic                 c1_arr, c2_arr, pf_q;
  logic                 gear_dirty, stale, div_start, div_busy, div_done;
  gpc_word_t            raw_sent, div_quot;
  gpc_word_t            rd_word;
  logic [`GPC_ST_W-1:0] next_status, ev;

  // software writes of the settings; out-of-range values are ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_one_target    <= `GPC_RST_C1_TARGET;
      counter_one_limit     <= `GPC_RST_C1_LIMIT;
      gear_divisor          <= `GPC_RST_GEAR;
      gear_multiplier       <= `GPC_RST_GEAR;
      counter_two_target    <= `GPC_RST_C2_TARGET;
      counter_two_limit     <= `GPC_RST_C2_LIMIT;
      wrap_behaviour_select <= `GPC_RST_WRAP;
      mask                  <= '0;
    end else if (reg_wr) begin
      // zero lies outside the target, limit and gear ranges, so such writes leave those settings alone
      if (reg_wdata != 32'h00000000) begin
        if (reg_addr == `GPC_OFF_C1_TARGET) counter_one_target <= reg_wdata; // see (RULE4)
        if (reg_addr == `GPC_OFF_C1_LIMIT) counter_one_limit <= reg_wdata; // see (RULE5)
        if (reg_addr == `GPC_OFF_GEAR_DIV && reg_wdata[31:16] == 16'h0000) begin
          gear_divisor <= reg_wdata[15:0]; // see (RULE10)
        end
        if (reg_addr == `GPC_OFF_GEAR_MUL && reg_wdata[31:16] == 16'h0000) begin
          gear_multiplier <= reg_wdata[15:0]; // see (RULE10)
        end
        if (reg_addr == `GPC_OFF_C2_TARGET && reg_wdata[31:16] == 16'h0000) begin
          counter_two_target <= reg_wdata[15:0]; // see (RULE2)
        end
        if (reg_addr == `GPC_OFF_C2_LIMIT && reg_wdata[31:16] == 16'h0000) begin
          counter_two_limit <= reg_wdata[15:0]; // see (RULE2)
        end
      end
      if (reg_addr == `GPC_OFF_MASK) mask <= reg_wdata[`GPC_ST_W-1:0];
      if (reg_addr == `GPC_OFF_WRAP_SEL && (reg_wdata == 32'(`GPC_WRAP_NONE)
          || reg_wdata == 32'(`GPC_WRAP_UNITS) || reg_wdata == 32'(`GPC_WRAP_TENS)
          || reg_wdata == 32'(`GPC_WRAP_BOTH))) begin
        wrap_behaviour_select <= reg_wdata[15:0]; // see (RULE6)
      end
    end
  end

  // terminal function code tables
  for (genvar i = 0; i < NUM_DI; i++) begin : g_di
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        di_func[i] <= 8'h00;
      end else if (wr_at(reg_addr, `GPC_OFF_DI_BASE + 8'(4 * i), reg_wr)) begin
        di_func[i] <= reg_wdata[7:0];
      end
    end
    assign di_codes[i*8 +: 8] = di_func[i];
  end
  for (genvar j = 0; j < NUM_DO; j++) begin : g_do
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        do_func[j] <= 8'h00;
        dout[j]    <= 1'b0;
      end else begin
        if (wr_at(reg_addr, `GPC_OFF_DO_BASE + 8'(4 * j), reg_wr)) begin
          do_func[j] <= reg_wdata[7:0];
        end
        dout[j] <= (do_func[j] == `GPC_FN_C1_ARRIVE && c1_arr) // see (RULE4)
                || (do_func[j] == `GPC_FN_C2_ARRIVE && c2_arr); // see (RULE11)
      end
    end
  end

  // terminal function selection
  gpc_term_sel #(.NUM_DI(NUM_DI), .CODE(`GPC_FN_C1_IN)) u_c1_in ( // see (RULE3)
    .clk(clk), .rst(rst), .din(din), .codes(di_codes), .level(), .rise(c1_pulse));
  gpc_term_sel #(.NUM_DI(NUM_DI), .CODE(`GPC_FN_C1_CLR)) u_c1_clr ( // see (RULE7)
    .clk(clk), .rst(rst), .din(din), .codes(di_codes), .level(c1_clr), .rise());
  gpc_term_sel #(.NUM_DI(NUM_DI), .CODE(`GPC_FN_C2_IN)) u_c2_in ( // see (RULE11)
    .clk(clk), .rst(rst), .din(din), .codes(di_codes), .level(), .rise(c2_pulse));
  gpc_term_sel #(.NUM_DI(NUM_DI), .CODE(`GPC_FN_C2_CLR)) u_c2_clr (
    .clk(clk), .rst(rst), .din(din), .codes(di_codes), .level(c2_clr), .rise());

  // overflow decisions
  assign c1_cont     = wrap_continues(wrap_behaviour_select, 1'b0); // see (RULE6)
  assign c2_cont     = wrap_continues(wrap_behaviour_select, 1'b1); // see (RULE6)
  assign c1_at_limit = c1_count_geared >= counter_one_limit;
  assign c2_at_limit = counter_two_value >= counter_two_limit;
  assign c1_ovf_ev   = c1_pulse && c1_at_limit && !c1_clr && !nv_restore;
  assign c2_ovf_ev   = c2_pulse && c2_at_limit && !c2_clr && !nv_restore;
  assign c1_wrap     = c1_ovf_ev && c1_cont;
  assign c2_wrap     = c2_ovf_ev && c2_cont;
  assign c1_zero     = c1_clr || c1_wrap || nv_restore;

  // counter one raw count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c1_count_raw <= '0;
    end else if (nv_restore) begin
      c1_count_raw <= nv_load_raw; // see (RULE9)
    end else if (c1_clr || c1_wrap) begin
      c1_count_raw <= '0; // see (RULE7)
    end else if (c1_pulse && !c1_at_limit) begin
      c1_count_raw <= c1_count_raw + 32'h00000001; // see (RULE1)
    end
  end

  // restart the gear calculation whenever count or ratio changed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_start  <= 1'b0;
      raw_sent   <= '0;
      gear_dirty <= 1'b0;
      stale      <= 1'b0;
    end else begin
      div_start <= !div_busy && !div_start && !c1_zero
                && (c1_count_raw != raw_sent || gear_dirty); // see (RULE10)
      if (c1_zero) begin
        raw_sent <= '0;
      end else if (!div_busy && !div_start) begin
        raw_sent <= c1_count_raw;
      end
      if (wr_at(reg_addr, `GPC_OFF_GEAR_DIV, reg_wr)
          || wr_at(reg_addr, `GPC_OFF_GEAR_MUL, reg_wr)) begin
        gear_dirty <= 1'b1;
      end else if (div_start) begin
        gear_dirty <= 1'b0;
      end
      if (c1_zero) begin
        stale <= 1'b1;
      end else if (div_start) begin
        stale <= 1'b0;
      end
    end
  end

  gpc_gear_div #(.CW(32)) u_gear (
    .clk(clk), .rst(rst), .start(div_start), .dividend(raw_sent),
    .mul(gear_multiplier), .den(gear_divisor),
    .busy(div_busy), .done(div_done), .quot(div_quot));

  // geared count, taken from the divider unless cleared meanwhile
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c1_count_geared <= '0;
    end else if (c1_zero) begin
      c1_count_geared <= '0;
    end else if (div_done && !stale) begin
      c1_count_geared <= div_quot; // see (RULE9)
    end
  end

  // counter two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_two_value <= '0;
    end else if (nv_restore) begin
      counter_two_value <= nv_load_c2; // see (RULE8)
    end else if (c2_clr || c2_wrap) begin
      counter_two_value <= '0; // see (RULE11)
    end else if (c2_pulse && !c2_at_limit) begin
      counter_two_value <= counter_two_value + 16'h0001; // see (RULE2)
    end
  end

  // target arrival levels and save request on power loss
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c1_arr  <= 1'b0;
      c2_arr  <= 1'b0;
      pf_q    <= 1'b0;
      nv_save <= 1'b0;
    end else begin
      c1_arr  <= c1_count_geared >= counter_one_target; // see (RULE4)
      c2_arr  <= counter_two_value >= counter_two_target; // see (RULE11)
      pf_q    <= power_fail;
      nv_save <= power_fail && !pf_q; // see (RULE8)
    end
  end

  // sticky events, write one to clear, set wins
  always_comb begin
    ev = '0;
    ev[`GPC_ST_C1_ARRIVE] = (c1_count_geared >= counter_one_target) && !c1_arr;
    ev[`GPC_ST_C1_OVF]    = c1_ovf_ev;
    ev[`GPC_ST_C2_ARRIVE] = (counter_two_value >= counter_two_target) && !c2_arr;
    ev[`GPC_ST_C2_OVF]    = c2_ovf_ev;
    next_status = status;
    if (wr_at(reg_addr, `GPC_OFF_STATUS, reg_wr)) begin
      next_status = status & ~reg_wdata[`GPC_ST_W-1:0];
    end
    next_status = next_status | ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(status & mask);
    end
  end

  // read decode
  always_comb begin
    rd_word = '0;
    unique case (reg_addr)
      `GPC_OFF_C1_RAW:    rd_word = c1_count_raw;
      `GPC_OFF_C1_GEARED: rd_word = c1_count_geared;
      `GPC_OFF_C1_TARGET: rd_word = counter_one_target;
      `GPC_OFF_C1_LIMIT:  rd_word = counter_one_limit;
      `GPC_OFF_GEAR_DIV:  rd_word = {16'h0000, gear_divisor};
      `GPC_OFF_GEAR_MUL:  rd_word = {16'h0000, gear_multiplier};
      `GPC_OFF_C2_VALUE:  rd_word = {16'h0000, counter_two_value};
      `GPC_OFF_C2_TARGET: rd_word = {16'h0000, counter_two_target};
      `GPC_OFF_C2_LIMIT:  rd_word = {16'h0000, counter_two_limit};
      `GPC_OFF_WRAP_SEL:  rd_word = {16'h0000, wrap_behaviour_select};
      `GPC_OFF_STATUS:    rd_word = {28'h0000000, status};
      `GPC_OFF_MASK:      rd_word = {28'h0000000, mask};
      default: begin
        for (int i = 0; i < NUM_DI; i++) begin
          if (reg_addr == `GPC_OFF_DI_BASE + 8'(4 * i)) rd_word = {24'h000000, di_func[i]};
        end
        for (int j = 0; j < NUM_DO; j++) begin
          if (reg_addr == `GPC_OFF_DO_BASE + 8'(4 * j)) rd_word = {24'h000000, do_func[j]};
        end
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_word : 32'h00000000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_c1_count;
    c1_pulse && !c1_clr && !nv_restore && !c1_at_limit;
  endsequence
  sequence s_c1_stop;
    c1_pulse && c1_at_limit && !c1_cont && !c1_clr && !nv_restore;
  endsequence

  c1_count_a: assert property (s_c1_count |=> // see (RULE3)
    c1_count_raw == $past(c1_count_raw) + 32'h00000001)
    else $error("counter one missed a pulse");
  c1_stop_a: assert property (s_c1_stop |=> $stable(c1_count_raw)) // see (RULE5)
    else $error("counter one moved past its maximum in stop mode");
  c1_wrap_a: assert property (c1_wrap |=> // see (RULE6)
    c1_count_raw == 32'h00000000 && c1_count_geared == 32'h00000000)
    else $error("counter one did not restart after overflow");
  clear_hold_a: assert property (c1_clr && !nv_restore |=> c1_count_raw == 32'h00000000) // see (RULE7)
    else $error("counter one not cleared by reset terminal");
  arrive_out_a: assert property ((c1_count_geared >= counter_one_target) && !c1_zero // see (RULE4)
    && do_func[0] == `GPC_FN_C1_ARRIVE ##1 do_func[0] == `GPC_FN_C1_ARRIVE |=> dout[0])
    else $error("arrival output missing");
  geared_take_a: assert property (div_done && !stale && !c1_zero |=> // see (RULE9)
    c1_count_geared == $past(div_quot))
    else $error("geared count not updated");
  c2_stop_a: assert property (c2_pulse && c2_at_limit && !c2_cont && !c2_clr // see (RULE2)
    && !nv_restore |=> $stable(counter_two_value))
    else $error("counter two moved past its maximum in stop mode");
  c2_clear_a: assert property (c2_clr && !nv_restore |=> counter_two_value == 16'h0000) // see (RULE11)
    else $error("counter two not cleared");
  restore_load_a: assert property (nv_restore |=> // see (RULE8)
    counter_two_value == $past(nv_load_c2) && c1_count_raw == $past(nv_load_raw))
    else $error("retained values not restored");
  irq_level_a: assert property (|(status & mask) |=> irq)
    else $error("interrupt not raised");
endmodule

//--- gpc_term_model.sv
`timescale 1ns/1ps
module gpc_term_model #(
  parameter int NUM_DI = 4
) (
  // clock
  input  wire logic              clk,
  // requests from the bench
  input  wire logic [NUM_DI-1:0] pulse_sel,
  input  wire logic [NUM_DI-1:0] hold_sel,
  // terminal levels
  output logic [NUM_DI-1:0]      din
);
  initial din = '0;
  // one-cycle pulses with a low cycle between them, held levels pass
  always @(posedge clk) begin
    din <= hold_sel | (pulse_sel & ~din);
  end
endmodule

//--- gpc_top_bench.sv
`timescale 1ns/1ps
module gpc_top_bench;
  import gpc_pkg::*;
  logic       clk, rst, reg_wr, reg_rd, power_fail, nv_restore, nv_save, irq;
  gpc_addr_t  reg_addr;
  gpc_word_t  reg_wdata, reg_rdata, c1_count_raw, c1_count_geared, nv_load_raw;
  gpc_half_t  nv_load_c2, counter_two_value;
  logic [3:0] din, pulse_sel, hold_sel;
  logic [1:0] dout;
  int         errors, n_tests;

  gpc_top #(.NUM_DI(4), .NUM_DO(2)) dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .din, .dout, .power_fail, .nv_restore, .nv_load_raw,
    .nv_load_c2, .nv_save, .c1_count_raw, .c1_count_geared, .counter_two_value, .irq);
  gpc_term_model #(.NUM_DI(4)) term (.clk, .pulse_sel, .hold_sel, .din);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one write cycle, then an idle cycle
  task automatic wr(input gpc_addr_t a, input gpc_word_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // read data are looked at in the cycle after the strobe
  task automatic rd(input gpc_addr_t a, input gpc_word_t e, input gpc_word_t m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata & m, e);
  endtask

  // n pulses, then 70 cycles, time for a single gear calculation and the outputs to settle
  task automatic pulse(input logic [3:0] sel, input int n);
    pulse_sel <= sel;
    repeat (2 * n) @(posedge clk);
    pulse_sel <= 4'h0;
    repeat (70) @(posedge clk);
  endtask

  task automatic wgear(input gpc_word_t e);
    int i;
    for (i = 0; i < 300 && c1_count_geared !== e; i++) @(posedge clk);
    chk(c1_count_geared, e);
    if (i == 300) close_out;
  endtask

  task automatic t_reset;
    gpc_addr_t a [8] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h24, 8'h2C};
    gpc_word_t e [8] = '{32'h3E8, 32'hFFFFFFFF, 32'h1, 32'h1, 32'h3E8, 32'hFFFF, 32'hB, 32'h0};
    foreach (a[i]) rd(a[i], e[i], '1);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h3E8, '1);
    wr(8'hFC, 32'h5);
    rd(8'hFC, 32'h0, '1);
    $display("test reset done");
  endtask

  task automatic t_gear;
    wr(8'h30, 32'h32);
    wr(8'h40, 32'h15);
    wr(8'h14, 32'h3);
    wr(8'h10, 32'h2);
    wr(8'h08, 32'h6);
    wr(8'h2C, 32'h1);
    pulse(4'h1, 4);
    chk(c1_count_raw, 32'h4);
    wgear(32'h6);
    repeat (4) @(posedge clk);
    chk(dout[0], 1'b1);
    chk(irq, 1'b1);
    rd(8'h04, 32'h6, '1);
    wr(8'h2C, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(8'h2C, 32'h1);
    wr(8'h28, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    pulse(4'h1, 1);
    wgear(32'h7);
    $display("test gear done");
  endtask

  task automatic t_clear;
    wr(8'h34, 32'h33);
    hold_sel <= 4'h2;
    pulse(4'h1, 1);
    chk(c1_count_raw, 32'h0);
    chk(dout[0], 1'b0);
    hold_sel <= 4'h0;
    wr(8'h34, 32'h0);
    $display("test clear done");
  endtask

  task automatic t_ovf;
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h1);
    wr(8'h0C, 32'h3);
    wr(8'h24, 32'hA);
    repeat (5) pulse(4'h1, 1);
    chk(c1_count_raw, 32'h3);
    rd(8'h28, 32'h2, 32'h2);
    wr(8'h24, 32'hB);
    pulse(4'h1, 1);
    chk(c1_count_raw, 32'h0);
    $display("test overflow done");
  endtask

  task automatic t_two;
    wr(8'h38, 32'h34);
    wr(8'h44, 32'h16);
    wr(8'h1C, 32'h2);
    wr(8'h20, 32'h2);
    wr(8'h24, 32'h1);
    repeat (4) pulse(4'h4, 1);
    chk(counter_two_value, 16'h2);
    chk(dout[1], 1'b1);
    wr(8'h18, 32'h9);
    rd(8'h18, 32'h2, '1);
    rd(8'h28, 32'hC, 32'hC);
    wr(8'h3C, 32'h35);
    hold_sel <= 4'h8;
    repeat (4) @(posedge clk);
    chk(counter_two_value, 16'h0);
    hold_sel <= 4'h0;
    wr(8'h24, 32'h0);
    wr(8'h24, 32'h5);
    rd(8'h24, 32'h0, '1);
    $display("test counter two done");
  endtask

  task automatic t_keep;
    int i;
    power_fail <= 1'b1;
    for (i = 0; i < 4 && nv_save !== 1'b1; i++) @(posedge clk);
    chk(nv_save, 1'b1);
    if (i == 4) close_out;
    @(posedge clk);
    chk(nv_save, 1'b0);
    nv_load_raw <= 32'h12345;
    nv_load_c2 <= 16'h77;
    nv_restore <= 1'b1;
    @(posedge clk);
    nv_restore <= 1'b0;
    @(posedge clk);
    chk(c1_count_raw, 32'h12345);
    chk(counter_two_value, 16'h77);
    $display("test retention done");
  endtask

  // reset for four cycles, then the scenarios in turn
  initial begin
    {rst, reg_wr, reg_rd, power_fail, nv_restore} = 5'b10000;
    {reg_addr, reg_wdata, nv_load_raw, nv_load_c2} = '0;
    {pulse_sel, hold_sel, errors, n_tests} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_gear();
    t_clear();
    t_ovf();
    t_two();
    t_keep();
    close_out();
  end
endmodule
